// ---- inc/pio_route_pkg.sv ----
package pio_route_pkg;

    localparam int          ADDR_W          = 44;
    localparam int          ROPE_W          = 3;
    localparam int          NUM_ROPES       = 8;
    localparam logic [15:0] DISP_LO         = 16'h03B0;
    localparam logic [15:0] DISP_HI         = 16'h03DF;
    localparam logic [9:0]  DISP_ALIAS_LO   = 10'h3B0;
    localparam logic [9:0]  DISP_ALIAS_HI   = 10'h3DF;
    localparam int          PORT_SEL_LSB    = 13;
    localparam int          DENSE_SEL_LSB   = 16;
    localparam int          DENSE_WIN_LSB   = 20;
    localparam int          FB_AREA_LSB     = 17;
    localparam logic [43:0] FB_BASE         = 44'h000000A0000;
    localparam int          HI_PORT_LSB     = 26;
    localparam int          HI_PAGE_LSB     = 12;
    localparam logic [43:0] LOW_DIST_TOP    = 44'h000FE000000;
    localparam logic [43:0] FOUR_GB         = 44'h00100000000;
    localparam int          SEL_LSB_W       = 6;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_MEM,
        KIND_PORT,
        KIND_MEM_LOW
    } fwd_kind_t;

endpackage : pio_route_pkg

// ---- logic/pio_rope_address_router.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - High window is one distributed range; low 64MB per share may be port space.
// - Enabled high window claims writes and forwards to the owning rope.
// - Remap option zeroes address bits 43:32 of high-window accesses, keeping the low 32 bits.
// - Port transactions claimed only while port distribution enable is set, except display ports 0x3B0-0x3DF with display enable set.
// - Display ports 0x3B0-0x3DF go to display rope before other checks.
// - Ten-bit display aliases follow display rope unless alias inhibit set.
// - Otherwise enabled directed port range routes to its programmed rope.
// - Otherwise port bits 15:13 select rope, 8KB each.
// - Combined ropes deliver member distributed addresses to primary rope.
// - Processor port-space writes are non-posted in every case.
// - Dense 1MB low window is port space, bits 18:16 pick rope, no display.
// - Next megabyte holds eight 128K display frame-buffer areas, one per rope.
// - Low 64MB of high share becomes non-posted port access, 4KB page to 4 bytes.
// - Directed ranges beat the distributed range where they overlap.
// - Low distributed window by base and size; rope bits start at select lsb.
// - Low distributed window stops below the top region of 4GB.
// - Two directed low ranges, each with base, size and target rope.
// - Display port range follows display routing controls for port transactions only, not in dense or high-window port space.
// - Display enable set claims display addresses; clear leaves them to port distribution, unclaimed while that is off.
module pio_rope_address_router
    import pio_route_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 req_valid_i,
    input  wire logic                 req_is_port_i,
    input  wire logic                 req_write_i,
    input  wire logic [ADDR_W-1:0]    req_addr_i,
    input  wire logic                 port_distribution_enable_reg_i,
    input  wire logic                 disp_route_en_i,
    input  wire logic                 disp_alias_inhibit_i,
    input  wire logic [ROPE_W-1:0]    disp_route_rope_i,
    input  wire logic                 dir_port_en_i,
    input  wire logic [15:0]          dir_port_base_i,
    input  wire logic [15:0]          dir_port_size_i,
    input  wire logic [ROPE_W-1:0]    dir_port_rope_i,
    input  wire logic                 low_dist_en_i,
    input  wire logic [ADDR_W-1:0]    low_distributed_base_i,
    input  wire logic [ADDR_W-1:0]    low_distributed_size_i,
    input  wire logic [SEL_LSB_W-1:0] low_distributed_select_i,
    input  wire logic [1:0]           low_dir_en_i,
    input  wire logic [ADDR_W-1:0]    low_directed_base0_i,
    input  wire logic [ADDR_W-1:0]    low_directed_size0_i,
    input  wire logic [ROPE_W-1:0]    low_directed_target0_i,
    input  wire logic [ADDR_W-1:0]    low_directed_base1_i,
    input  wire logic [ADDR_W-1:0]    low_directed_size1_i,
    input  wire logic [ROPE_W-1:0]    low_directed_target1_i,
    input  wire logic                 dense_port_en_i,
    input  wire logic [ADDR_W-1:0]    dense_port_base_i,
    input  wire logic                 fb_win_en_i,
    input  wire logic                 high_win_en_i,
    input  wire logic [ADDR_W-1:0]    high_win_base_i,
    input  wire logic [ADDR_W-1:0]    high_win_size_i,
    input  wire logic [SEL_LSB_W-1:0] high_win_select_i,
    input  wire logic                 high_port_en_i,
    input  wire logic [NUM_ROPES-1:0] high_remap_i,
    input  wire logic [NUM_ROPES-1:0] rope_width2_i,
    input  wire logic [NUM_ROPES-1:0] rope_width4_i,
    output logic                      claim_o,
    output logic [ROPE_W-1:0]         rope_o,
    output logic [2:0]                kind_o,
    output logic                      nonposted_o,
    output logic [ADDR_W-1:0]         fwd_addr_o
);

    logic                 dir_hit0;
    logic                 dir_hit1;
    logic                 dist_hit;
    logic                 high_hit;
    logic                 dir_port_hit;
    logic                 dense_hit;
    logic                 fb_hit;
    logic [ADDR_W-1:0]    low_rel;
    logic [ADDR_W-1:0]    high_rel;
    logic [ADDR_W-1:0]    low_sh;
    logic [ADDR_W-1:0]    high_sh;
    logic [ROPE_W-1:0]    dist_rope;
    logic [ROPE_W-1:0]    high_rope;
    logic                 high_low64;
    logic [15:0]          port;
    logic                 disp_exact;
    logic                 disp_alias;
    logic                 claim_nxt;
    logic [ROPE_W-1:0]    rope_nxt;
    logic [ROPE_W-1:0]    rope_pre;
    fwd_kind_t            kind_nxt;
    logic                 np_nxt;
    logic [ADDR_W-1:0]    addr_nxt;
    logic                 do_combine;

    range_hit #(.W(ADDR_W)) u_dir0 (
        .addr_i (req_addr_i),
        .base_i (low_directed_base0_i),
        .size_i (low_directed_size0_i),
        .en_i   (low_dir_en_i[0]),
        .hit_o  (dir_hit0)
    );

    range_hit #(.W(ADDR_W)) u_dir1 (
        .addr_i (req_addr_i),
        .base_i (low_directed_base1_i),
        .size_i (low_directed_size1_i),
        .en_i   (low_dir_en_i[1]),
        .hit_o  (dir_hit1)
    );

    range_hit #(.W(ADDR_W)) u_dist (
        .addr_i (req_addr_i),
        .base_i (low_distributed_base_i),
        .size_i (low_distributed_size_i),
        .en_i   (low_dist_en_i && (req_addr_i < LOW_DIST_TOP)),
        .hit_o  (dist_hit)
    );

    range_hit #(.W(ADDR_W)) u_high (
        .addr_i (req_addr_i),
        .base_i (high_win_base_i),
        .size_i (high_win_size_i),
        .en_i   (high_win_en_i && (req_addr_i >= FOUR_GB)),
        .hit_o  (high_hit)
    );

    range_hit #(.W(16)) u_dport (
        .addr_i (port),
        .base_i (dir_port_base_i),
        .size_i (dir_port_size_i),
        .en_i   (dir_port_en_i),
        .hit_o  (dir_port_hit)
    );

    assign port       = req_addr_i[15:0];
    assign dense_hit  = dense_port_en_i
                      && (req_addr_i[ADDR_W-1:DENSE_WIN_LSB]
                          == dense_port_base_i[ADDR_W-1:DENSE_WIN_LSB]);
    assign fb_hit     = fb_win_en_i && (req_addr_i[ADDR_W-1:DENSE_WIN_LSB]
                          == (dense_port_base_i[ADDR_W-1:DENSE_WIN_LSB] + 1'b1));
    assign low_rel    = req_addr_i - low_distributed_base_i;
    assign high_rel   = req_addr_i - high_win_base_i;
    assign low_sh     = low_rel >> low_distributed_select_i;
    assign high_sh    = high_rel >> high_win_select_i;
    assign dist_rope  = low_sh[ROPE_W-1:0];
    assign high_rope  = high_sh[ROPE_W-1:0];
    assign high_low64 = high_port_en_i
                      && ((high_rel & ((44'h1 << high_win_select_i) - 44'h1))
                          < (44'h1 << HI_PORT_LSB));
    assign disp_exact = (port >= DISP_LO) && (port <= DISP_HI);
    assign disp_alias = (port[9:0] >= DISP_ALIAS_LO)
                      && (port[9:0] <= DISP_ALIAS_HI);

    always_comb
    begin
        claim_nxt  = 1'b0;
        rope_pre   = '0;
        kind_nxt   = KIND_NONE;
        np_nxt     = 1'b0;
        addr_nxt   = req_addr_i;
        do_combine = 1'b0;
        if (req_valid_i && req_is_port_i)
        begin
            if (port_distribution_enable_reg_i)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_PORT;
                np_nxt    = 1'b1;
                addr_nxt  = {{(ADDR_W-16){1'b0}}, port};
                if (disp_route_en_i && disp_exact)
                    rope_pre = disp_route_rope_i;
                else if (disp_route_en_i && !disp_alias_inhibit_i && disp_alias)
                    rope_pre = disp_route_rope_i;
                else if (dir_port_hit)
                    rope_pre = dir_port_rope_i;
                else
                begin
                    rope_pre   = port[PORT_SEL_LSB+ROPE_W-1:PORT_SEL_LSB];
                    do_combine = 1'b1;
                end
            end
            else if (disp_route_en_i && disp_exact)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_PORT;
                np_nxt    = 1'b1;
                rope_pre  = disp_route_rope_i;
                addr_nxt  = {{(ADDR_W-16){1'b0}}, port};
            end
        end
        else if (req_valid_i)
        begin
            if (dense_hit)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_PORT;
                np_nxt    = 1'b1;
                rope_pre  = req_addr_i[DENSE_SEL_LSB+ROPE_W-1:DENSE_SEL_LSB];
                addr_nxt  = {{(ADDR_W-16){1'b0}}, port};
            end
            else if (fb_hit)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_MEM_LOW;
                rope_pre  = req_addr_i[FB_AREA_LSB+ROPE_W-1:FB_AREA_LSB];
                addr_nxt  = FB_BASE | {27'h0, req_addr_i[FB_AREA_LSB-1:0]};
            end
            else if (dir_hit0)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_MEM;
                rope_pre  = low_directed_target0_i;
            end
            else if (dir_hit1)
            begin
                claim_nxt = 1'b1;
                kind_nxt  = KIND_MEM;
                rope_pre  = low_directed_target1_i;
            end
            else if (dist_hit)
            begin
                claim_nxt  = 1'b1;
                kind_nxt   = KIND_MEM;
                rope_pre   = dist_rope;
                do_combine = 1'b1;
            end
            else if (high_hit)
            begin
                claim_nxt  = 1'b1;
                rope_pre   = high_rope;
                do_combine = 1'b1;
                if (high_low64)
                begin
                    kind_nxt = KIND_PORT;
                    np_nxt   = 1'b1;
                    addr_nxt = {{(ADDR_W-16){1'b0}},
                                req_addr_i[HI_PORT_LSB-1:HI_PAGE_LSB],
                                req_addr_i[1:0]};
                end
                else if (high_remap_i[high_rope])
                begin
                    kind_nxt = KIND_MEM_LOW;
                    addr_nxt = {{(ADDR_W-32){1'b0}}, req_addr_i[31:0]};
                end
                else
                    kind_nxt = KIND_MEM;
            end
        end
    end

    // Member ropes of a combined group fold onto the primary
    always_comb
    begin
        rope_nxt = rope_pre;
        if (do_combine)
        begin
            if (rope_width4_i[{rope_pre[2], 2'b00}])
                rope_nxt = {rope_pre[2], 2'b00};
            else if (rope_width2_i[{rope_pre[2:1], 1'b0}])
                rope_nxt = {rope_pre[2:1], 1'b0};
        end
    end

    // Claim flag
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            claim_o <= 1'b0;
        else if (clk_en_i)
            claim_o <= claim_nxt;
    end

    // Destination rope
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rope_o <= '0;
        else if (clk_en_i)
            rope_o <= rope_nxt;
    end

    // Forwarded transaction kind
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            kind_o <= 3'h0;
        else if (clk_en_i)
            kind_o <= kind_nxt;
    end

    // Non-posted marker
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            nonposted_o <= 1'b0;
        else if (clk_en_i)
            nonposted_o <= np_nxt;
    end

    // Forwarded address
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            fwd_addr_o <= '0;
        else if (clk_en_i)
            fwd_addr_o <= addr_nxt;
    end

endmodule : pio_rope_address_router
`default_nettype wire

// ---- logic/range_hit.sv ----
`timescale 1ns/1ps
`default_nettype none
module range_hit
    import pio_route_pkg::*;
#(
    parameter int W = 44
)(
    input  wire logic [W-1:0] addr_i,
    input  wire logic [W-1:0] base_i,
    input  wire logic [W-1:0] size_i,
    input  wire logic         en_i,
    output logic              hit_o
);
    // Size holds ones on the bits that are ignored inside the range
    assign hit_o = en_i && (((addr_i ^ base_i) & ~size_i) == '0);
endmodule : range_hit
`default_nettype wire

// ---- verif/pio_rope_address_router_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pio_rope_address_router_asserts
    import pio_route_pkg::*;
(
    input wire logic                 mclk_i, arst_n_i, clk_en_i, req_valid_i, req_is_port_i,
    input wire logic                 port_distribution_enable_reg_i, disp_route_en_i,
    input wire logic                 disp_alias_inhibit_i, dir_port_en_i, dense_port_en_i,
    input wire logic [ROPE_W-1:0]    disp_route_rope_i,
    input wire logic [ADDR_W-1:0]    req_addr_i, dense_port_base_i,
    input wire logic [NUM_ROPES-1:0] rope_width2_i, rope_width4_i,
    input wire logic                 claim_o, nonposted_o,
    input wire logic [ROPE_W-1:0]    rope_o,
    input wire logic [2:0]           kind_o,
    input wire logic [ADDR_W-1:0]    fwd_addr_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic [15:0] pa;
    logic        plain;
    assign pa = req_addr_i[15:0];
    assign plain = !dir_port_en_i && rope_width2_i == '0 && rope_width4_i == '0;
    sequence s_take;
        clk_en_i && req_valid_i;
    endsequence
    sequence s_port;
        s_take ##0 req_is_port_i;
    endsequence
    sequence s_alias;
        s_port ##0 port_distribution_enable_reg_i && disp_route_en_i && disp_alias_inhibit_i
            && pa[9:0] >= DISP_ALIAS_LO && pa[9:0] <= DISP_ALIAS_HI && pa[15:10] != '0;
    endsequence
    AST_DISP_ROUTE: assert property (s_port ##0 disp_route_en_i && pa >= DISP_LO
        && pa <= DISP_HI |=> claim_o && kind_o == KIND_PORT && rope_o == $past(disp_route_rope_i))
        else $error("display port misrouted");
    AST_ALIAS_INHIBIT: assert property (s_alias ##0 plain |=> rope_o == $past(pa[15:13]))
        else $error("inhibited alias sent to display rope");
    AST_PORT_OFF: assert property (s_port ##0 !port_distribution_enable_reg_i
        && !disp_route_en_i |=> !claim_o) else $error("port claimed while disabled");
    AST_PORT_BITS: assert property (s_port ##0 port_distribution_enable_reg_i
        && !disp_route_en_i && plain |=> claim_o && rope_o == $past(pa[15:13]))
        else $error("port bits rope wrong");
    AST_DENSE: assert property (s_take ##0 !req_is_port_i && dense_port_en_i
        && req_addr_i[43:20] == dense_port_base_i[43:20]
        |=> claim_o && kind_o == KIND_PORT && rope_o == $past(req_addr_i[18:16]))
        else $error("dense window misrouted");
    AST_PORT_NONPOSTED: assert property (claim_o && kind_o == KIND_PORT |-> nonposted_o)
        else $error("port access posted");
    AST_REMAP_LOW: assert property (claim_o && kind_o == KIND_MEM_LOW
        |-> fwd_addr_o[43:32] == '0) else $error("remap kept upper bits");
    AST_NO_REQUEST: assert property (clk_en_i && !req_valid_i |=> !claim_o)
        else $error("claim without request");
    AST_UNCLAIMED: assert property (!claim_o |-> kind_o == KIND_NONE && rope_o == '0)
        else $error("unclaimed output not cleared");
    AST_FROZEN: assert property (!clk_en_i |=> $stable(claim_o) && $stable(rope_o)
        && $stable(fwd_addr_o)) else $error("outputs moved while frozen");
endmodule : pio_rope_address_router_asserts
bind pio_rope_address_router pio_rope_address_router_asserts u_chk (.*);
`default_nettype wire

// ---- verif/pio_rope_address_router_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pio_rope_address_router_tb;
    import pio_route_pkg::*;
    logic mclk_i, arst_n_i, clk_en_i, req_valid_i, req_is_port_i, req_write_i, claim_o;
    logic port_distribution_enable_reg_i, disp_route_en_i, disp_alias_inhibit_i, nonposted_o;
    logic dir_port_en_i, low_dist_en_i, dense_port_en_i, fb_win_en_i, high_win_en_i;
    logic high_port_en_i;
    logic [1:0] low_dir_en_i;
    logic [2:0] kind_o;
    logic [15:0] dir_port_base_i, dir_port_size_i;
    logic [ROPE_W-1:0] disp_route_rope_i, dir_port_rope_i, rope_o;
    logic [ROPE_W-1:0] low_directed_target0_i, low_directed_target1_i;
    logic [SEL_LSB_W-1:0] low_distributed_select_i, high_win_select_i;
    logic [NUM_ROPES-1:0] high_remap_i, rope_width2_i, rope_width4_i, seen;
    logic [ADDR_W-1:0] req_addr_i, low_distributed_base_i, low_distributed_size_i;
    logic [ADDR_W-1:0] low_directed_base0_i, low_directed_size0_i, low_directed_base1_i;
    logic [ADDR_W-1:0] low_directed_size1_i, dense_port_base_i, high_win_base_i;
    logic [ADDR_W-1:0] high_win_size_i, fwd_addr_o;
    int n_fail, tests_run;

    pio_rope_address_router dut (.*);
    rope_guest_model guest (.mclk_i, .arst_n_i, .claim_i(claim_o), .rope_i(rope_o), .seen_o(seen));

    task automatic cmp(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : cmp

    task automatic tr(input logic p, input logic [ADDR_W-1:0] x, input logic c,
                      input logic [ROPE_W-1:0] r, input logic [2:0] k);
        req_valid_i = 1'b1;
        req_is_port_i = p;
        req_write_i = 1'b1;
        req_addr_i = x;
        @(negedge mclk_i);
        cmp({claim_o, rope_o, kind_o, nonposted_o}, {c, r, k, k == KIND_PORT});
    endtask : tr

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    initial
    begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        {arst_n_i, req_valid_i, req_is_port_i, req_write_i, req_addr_i, high_remap_i} = '0;
        {port_distribution_enable_reg_i, disp_route_en_i, disp_alias_inhibit_i} = '0;
        {disp_route_rope_i, dir_port_en_i, dir_port_base_i, dir_port_size_i} = '0;
        {dir_port_rope_i, low_dist_en_i, low_distributed_base_i, low_distributed_size_i} = '0;
        {low_distributed_select_i, low_dir_en_i, low_directed_base0_i} = '0;
        {low_directed_size0_i, low_directed_target0_i, low_directed_base1_i} = '0;
        {low_directed_size1_i, low_directed_target1_i, dense_port_en_i, fb_win_en_i} = '0;
        {dense_port_base_i, high_win_en_i, high_win_base_i, high_win_size_i} = '0;
        {high_win_select_i, high_port_en_i, rope_width2_i, rope_width4_i} = '0;
        n_fail = 0;
        tests_run = 0;
        clk_en_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        tr(1'b1, 44'h3B5, 1'b0, 3'h0, KIND_NONE);
        port_distribution_enable_reg_i = 1'b1;
        disp_route_en_i = 1'b1;
        disp_route_rope_i = 3'h5;
        tr(1'b1, 44'h3B5, 1'b1, 3'h5, KIND_PORT);
        cmp(fwd_addr_o, 44'h3B5);
        tr(1'b1, 44'h3DF, 1'b1, 3'h5, KIND_PORT);
        tr(1'b1, 44'h3E0, 1'b1, 3'h0, KIND_PORT);
        tr(1'b1, 44'h7B0, 1'b1, 3'h5, KIND_PORT);
        disp_alias_inhibit_i = 1'b1;
        tr(1'b1, 44'hFFB0, 1'b1, 3'h7, KIND_PORT);
        tr(1'b1, 44'h3B0, 1'b1, 3'h5, KIND_PORT);
        for (int i = 0; i < NUM_ROPES; i++)
            tr(1'b1, 44'h100 | (44'(i) << 13), 1'b1, ROPE_W'(i), KIND_PORT);
        {dir_port_en_i, dir_port_base_i, dir_port_size_i, dir_port_rope_i} = {1'b1, 16'h4000, 16'h0FFF, 3'h6};
        tr(1'b1, 44'h4010, 1'b1, 3'h6, KIND_PORT);
        tr(1'b1, 44'h3C0, 1'b1, 3'h5, KIND_PORT);
        port_distribution_enable_reg_i = 1'b0;
        tr(1'b1, 44'h3C0, 1'b1, 3'h5, KIND_PORT);
        tr(1'b1, 44'h2000, 1'b0, 3'h0, KIND_NONE);
        disp_route_en_i = 1'b0;
        tr(1'b1, 44'h3C0, 1'b0, 3'h0, KIND_NONE);
        {port_distribution_enable_reg_i, dir_port_en_i, rope_width2_i} = {1'b1, 1'b0, 8'h04};
        tr(1'b1, 44'h6100, 1'b1, 3'h2, KIND_PORT);
        rope_width2_i = 8'h00;
        $display("test port_space done");
        {dense_port_en_i, dense_port_base_i, disp_route_en_i} = {1'b1, 44'h6000_0000, 1'b1};
        tr(1'b0, 44'h6005_1234, 1'b1, 3'h5, KIND_PORT);
        cmp(fwd_addr_o, 44'h1234);
        tr(1'b0, 44'h600D_1234, 1'b1, 3'h5, KIND_PORT);
        tr(1'b0, 44'h6000_03C0, 1'b1, 3'h0, KIND_PORT);
        fb_win_en_i = 1'b1;
        tr(1'b0, 44'h6016_0040, 1'b1, 3'h3, KIND_MEM_LOW);
        cmp(fwd_addr_o, 44'hA0040);
        $display("test dense_window done");
        {low_dist_en_i, low_distributed_base_i} = {1'b1, 44'h8000_0000};
        {low_distributed_size_i, low_distributed_select_i} = {44'h7FFF_FFFF, 6'h1C};
        for (int i = 0; i < 7; i++)
            tr(1'b0, 44'h8000_0100 + (44'(i) << 28), 1'b1, ROPE_W'(i), KIND_MEM);
        tr(1'b0, 44'hFDFF_FFF0, 1'b1, 3'h7, KIND_MEM);
        tr(1'b0, 44'hFE00_0000, 1'b0, 3'h0, KIND_NONE);
        {low_directed_base0_i, low_directed_size0_i} = {44'hC000_0000, 44'h0FFF_FFFF};
        {low_directed_base1_i, low_directed_size1_i} = {44'hD000_0000, 44'h0FFF_FFFF};
        {low_dir_en_i, low_directed_target0_i, low_directed_target1_i} = {2'h3, 3'h2, 3'h5};
        tr(1'b0, 44'hC123_0000, 1'b1, 3'h2, KIND_MEM);
        tr(1'b0, 44'hD000_0010, 1'b1, 3'h5, KIND_MEM);
        rope_width4_i = 8'h10;
        tr(1'b0, 44'hE000_0000, 1'b1, 3'h4, KIND_MEM);
        rope_width4_i = 8'h00;
        $display("test low_window done");
        {high_win_en_i, high_win_base_i, high_win_select_i} = {1'b1, 44'h100_0000_0000, 6'h24};
        high_win_size_i = 44'h07F_FFFF_FFFF;
        tr(1'b0, 44'h131_2345_6780, 1'b1, 3'h3, KIND_MEM);
        cmp(fwd_addr_o, 44'h131_2345_6780);
        high_remap_i = 8'h08;
        tr(1'b0, 44'h131_2345_6780, 1'b1, 3'h3, KIND_MEM_LOW);
        cmp(fwd_addr_o, 44'h2345_6780);
        {high_remap_i, high_port_en_i} = {8'h00, 1'b1};
        tr(1'b0, 44'h130_0000_5002, 1'b1, 3'h3, KIND_PORT);
        cmp(fwd_addr_o, 44'h16);
        clk_en_i = 1'b0;
        tr(1'b0, 44'h0, 1'b1, 3'h3, KIND_PORT);
        clk_en_i = 1'b1;
        high_win_en_i = 1'b0;
        tr(1'b0, 44'h131_2345_6780, 1'b0, 3'h0, KIND_NONE);
        $display("test high_window done");
        cmp(44'(seen), 44'hFF);
        req_valid_i = 1'b0;
        arst_n_i = 1'b0;
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        @(negedge mclk_i);
        cmp({claim_o, rope_o, kind_o, nonposted_o}, 44'h0);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : pio_rope_address_router_tb
`default_nettype wire

// ---- verif/rope_guest_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rope_guest_model
    import pio_route_pkg::*;
(
    input  wire logic                 mclk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 claim_i,
    input  wire logic [ROPE_W-1:0]    rope_i,
    output logic      [NUM_ROPES-1:0] seen_o
);
    // Marks every rope that received an access; issues no peer writes of its own
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            seen_o <= '0;
        else if (claim_i)
            seen_o[rope_i] <= 1'b1;
    end
endmodule : rope_guest_model
`default_nettype wire
